// File: design/spc_defs.svh
// Offsets, field positions, reset values and timing counts of the port.
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH
`define SPC_OFS_CTRL     8'h00
`define SPC_OFS_MODE     8'h04
`define SPC_OFS_STAT     8'h08
`define SPC_OFS_TXB      8'h0c
`define SPC_OFS_RXB      8'h10
`define SPC_OFS_PORT     8'h14
`define SPC_OFS_STOP     8'h18
`define SPC_OFS_REQ      8'h1c
`define SPC_B_TIE        0
`define SPC_B_RIE        1
`define SPC_B_TE         2
`define SPC_B_RE         3
`define SPC_B_TX_END_IRQ_ENABLE       4
`define SPC_B_SMART      0
`define SPC_B_SYNC       1
`define SPC_B_TX_BUFFER_EMPTY_FLAG       0
`define SPC_B_TX_END_FLAG       1
`define SPC_B_RX_FULL_FLAG       2
`define SPC_B_OVERRUN_ERROR_FLAG       3
`define SPC_B_FER        4
`define SPC_B_PER        5
`define SPC_B_ERS        6
`define SPC_B_PDATA      0
`define SPC_B_PDIR       1
`define SPC_STOP_RST     1'b1
`define SPC_RESP_OKAY    2'h0
`define SPC_RESP_SLVERR  2'h2
`define SPC_VEC_NONE     3'h0
`define SPC_VEC_RXERR    3'h1
`define SPC_VEC_RXFULL   3'h2
`define SPC_VEC_TXEMPTY  3'h3
`define SPC_VEC_TXEND    3'h4
`define SPC_FRAME_BITS   4'ha
`define SPC_BIT_CYCLES   5'h10
`endif

// File: design/spc_pkg.sv
// Types shared by the serial port flag and request logic.
package spc_pkg;
  typedef enum logic {SPC_TX_IDLE, SPC_TX_SHIFT} spc_tx_e;
  typedef struct packed {
    logic tx_end_irq_enable;
    logic receive_enable_bit;
    logic transmit_enable_bit;
    logic rx_irq_enable;
    logic tx_empty_irq_enable;
  } spc_ctrl_s;
  typedef struct packed {
    logic clocked_sync;
    logic smart_card;
  } spc_mode_s;
  typedef struct packed {
    logic error_signal_received_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic rx_full_flag;
    logic tx_end_flag;
    logic tx_buffer_empty_flag;
  } spc_flags_s;
  typedef struct packed {
    logic rx_error_request;
    logic rx_full_request;
    logic tx_empty_request;
    logic tx_end_request;
  } spc_req_s;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       parity_err;
    logic       framing_err;
  } spc_rx_frame_s;
  typedef struct packed {
    spc_ctrl_s  c;
    spc_mode_s  m;
    spc_flags_s f;
    logic        stop;
    logic        port_data;
    logic        port_dir;
    spc_tx_e     tx_st;
    logic [7:0]  tx_buf;
    logic [7:0]  tx_hold;
    logic [9:0]  shift;
    logic [3:0]  bitcnt;
    logic [4:0]  timer;
    logic [7:0]  rx_buf;
    spc_req_s    req;
    logic [2:0]  vec;
    logic        txd_o;
    logic        txd_oe;
    logic        awready;
    logic        wready;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_addr;
    logic [7:0]  w_data;
    logic        w_strb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } spc_state_s;
endpackage

// File: design/spc_port.sv
// Serial port request, status flag and DMA trigger logic with AXI4-Lite.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`include "spc_defs.svh"
module spc_port
  import spc_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    awaddr,
  input  wire logic          awvalid,
  output      logic          awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output      logic          wready,
  output      logic [1:0]    bresp,
  output      logic          bvalid,
  input  wire logic          bready,
  input  wire logic [7:0]    araddr,
  input  wire logic          arvalid,
  output      logic          arready,
  output      logic [31:0]   rdata,
  output      logic [1:0]    rresp,
  output      logic          rvalid,
  input  wire logic          rready,
  input  wire spc_rx_frame_s rx_frame,
  input  wire logic          card_error_signal,
  input  wire logic          dma_tx_wr,
  input  wire logic [7:0]    dma_tx_data,
  input  wire logic          dma_rx_ack,
  output      logic [7:0]    dma_rx_data,
  output      spc_req_s      irq,
  output      logic [2:0]    irq_vector,
  output      logic          dma_tx_req,
  output      logic          dma_rx_req,
  output      logic          txd_o,
  output      logic          txd_oe
);

  spc_state_s state_reg;
  spc_state_s state_next;
  logic       do_wr;
  logic       buf_wr;
  logic       err_any;
  logic       sync_err;

  ////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the state register.
  assign awready     = state_reg.awready;
  assign wready      = state_reg.wready;
  assign bresp       = state_reg.bresp;
  assign bvalid      = state_reg.bvalid;
  assign arready     = state_reg.arready;
  assign rdata       = state_reg.rdata;
  assign rresp       = state_reg.rresp;
  assign rvalid      = state_reg.rvalid;
  assign dma_rx_data = state_reg.rx_buf;
  assign irq         = state_reg.req;
  assign irq_vector  = state_reg.vec;
  assign dma_tx_req  = state_reg.req.tx_empty_request;
  assign dma_rx_req  = state_reg.req.rx_full_request;
  assign txd_o       = state_reg.txd_o;
  assign txd_oe      = state_reg.txd_oe;

  ////////////////////////////////////////////////////////////////////////
  // Next state: bus access, DMA, transmitter, receiver, then requests.
  always_comb begin
    logic [7:0] wd;
    logic       hit;
    wd         = '0;
    hit        = 1'b0;
    state_next = state_reg;
    do_wr      = 1'b0;
    buf_wr     = 1'b0;
    err_any    = 1'b0;
    sync_err   = 1'b0;

    // Address and data channels are taken independently.
    if (state_reg.awready && awvalid) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = awaddr;
    end
    if (state_reg.wready && wvalid) begin
      state_next.w_full  = 1'b1;
      state_next.w_data  = wdata[7:0];
      state_next.w_strb0 = wstrb[0];
    end
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end

    // A write completes once both halves are held.
    if (state_reg.aw_full && state_reg.w_full && !state_reg.bvalid) begin
      state_next.aw_full = 1'b0;
      state_next.w_full  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = `SPC_RESP_OKAY;
      wd = state_reg.w_data;
      if (state_reg.aw_addr == `SPC_OFS_STOP) begin
        hit = 1'b1;
        if (state_reg.w_strb0) begin
          state_next.stop = wd[0];
        end
      end else if (!state_reg.stop) begin
        hit   = 1'b1;
        do_wr = state_reg.w_strb0;
        case (state_reg.aw_addr)
          `SPC_OFS_CTRL, `SPC_OFS_MODE, `SPC_OFS_STAT,
          `SPC_OFS_TXB, `SPC_OFS_RXB, `SPC_OFS_PORT,
          `SPC_OFS_REQ: hit = 1'b1;
          default: begin
            hit   = 1'b0;
            do_wr = 1'b0;
          end
        endcase
      end
      if (!hit) begin
        state_next.bresp = `SPC_RESP_SLVERR;
      end
    end

    // Register stores; status bits written 0 are cleared, the end flag with the empty bit.
    if (do_wr) begin
      case (state_reg.aw_addr)
        `SPC_OFS_CTRL: begin
          state_next.c.tx_empty_irq_enable = wd[`SPC_B_TIE];
          state_next.c.rx_irq_enable       = wd[`SPC_B_RIE];
          state_next.c.transmit_enable_bit = wd[`SPC_B_TE];
          state_next.c.receive_enable_bit  = wd[`SPC_B_RE];
          state_next.c.tx_end_irq_enable   = wd[`SPC_B_TX_END_IRQ_ENABLE];
        end
        `SPC_OFS_MODE: begin
          state_next.m.smart_card   = wd[`SPC_B_SMART];
          state_next.m.clocked_sync = wd[`SPC_B_SYNC];
        end
        `SPC_OFS_STAT: begin
          if (!wd[`SPC_B_TX_BUFFER_EMPTY_FLAG]) begin
            state_next.f.tx_buffer_empty_flag = 1'b0;
            state_next.f.tx_end_flag          = 1'b0;
          end
          if (!wd[`SPC_B_RX_FULL_FLAG]) begin
            state_next.f.rx_full_flag = 1'b0;
          end
          if (!wd[`SPC_B_OVERRUN_ERROR_FLAG]) begin
            state_next.f.overrun_error_flag = 1'b0;
          end
          if (!wd[`SPC_B_FER]) begin
            state_next.f.framing_error_flag = 1'b0;
          end
          if (!wd[`SPC_B_PER]) begin
            state_next.f.parity_error_flag = 1'b0;
          end
          if (!wd[`SPC_B_ERS]) begin
            state_next.f.error_signal_received_flag = 1'b0;
          end
        end
        `SPC_OFS_TXB: begin
          state_next.tx_buf = wd;
          buf_wr = 1'b1;
        end
        `SPC_OFS_PORT: begin
          state_next.port_data = wd[`SPC_B_PDATA];
          state_next.port_dir  = wd[`SPC_B_PDIR];
        end
        default: begin
        end
      endcase
    end

    // DMA transmit write clears the empty and end flags; a card-mode frame ending without a card error in the same cycle sets them again.
    if (dma_tx_wr && !state_reg.stop) begin
      state_next.tx_buf                 = dma_tx_data;
      state_next.f.tx_buffer_empty_flag = 1'b0;
      state_next.f.tx_end_flag          = 1'b0;
      buf_wr = 1'b1;
    end
    // DMA read of the receive buffer clears the full flag.
    if (dma_rx_ack && !state_reg.stop) begin
      state_next.f.rx_full_flag = 1'b0;
    end

    // Receive errors that hold off a synchronous transmission.
    sync_err = state_reg.m.clocked_sync &&
               (state_reg.f.overrun_error_flag ||
                state_reg.f.framing_error_flag ||
                state_reg.f.parity_error_flag);

    // Transmitter; a buffer write in the same cycle delays the load.
    case (state_reg.tx_st)
      SPC_TX_IDLE: begin
        if (state_reg.c.transmit_enable_bit &&
            !state_reg.f.tx_buffer_empty_flag && !buf_wr &&
            !sync_err) begin
          state_next.shift   = {1'b1, state_reg.tx_buf, 1'b0};
          state_next.tx_hold = state_reg.tx_buf;
          state_next.bitcnt  = `SPC_FRAME_BITS;
          state_next.timer   = `SPC_BIT_CYCLES;
          state_next.tx_st   = SPC_TX_SHIFT;
          state_next.f.tx_end_flag = 1'b0;
          if (!state_reg.m.smart_card) begin
            state_next.f.tx_buffer_empty_flag = 1'b1;
          end
        end
      end
      SPC_TX_SHIFT: begin
        state_next.timer = state_reg.timer - 5'h01;
        if (state_reg.timer == 5'h01) begin
          state_next.timer  = `SPC_BIT_CYCLES;
          state_next.shift  = {1'b1, state_reg.shift[9:1]};
          state_next.bitcnt = state_reg.bitcnt - 4'h1;
          if (state_reg.bitcnt == 4'h1) begin
            state_next.tx_st = SPC_TX_IDLE;
            if (!state_reg.m.smart_card) begin
              if (state_reg.f.tx_buffer_empty_flag && !buf_wr) begin
                state_next.f.tx_end_flag = 1'b1;
              end
            end else if (card_error_signal) begin
              // Resend the same byte; end flag stays low.
              state_next.f.error_signal_received_flag = 1'b1;
              state_next.shift  = {1'b1, state_reg.tx_hold, 1'b0};
              state_next.bitcnt = `SPC_FRAME_BITS;
              state_next.tx_st  = SPC_TX_SHIFT;
            end else begin
              state_next.f.tx_end_flag          = 1'b1;
              state_next.f.tx_buffer_empty_flag = 1'b1;
            end
          end
        end
      end
      default: state_next.tx_st = SPC_TX_IDLE;
    endcase

    // Transmit disable reinitialises the transmitter.
    if (!state_next.c.transmit_enable_bit) begin
      state_next.tx_st                  = SPC_TX_IDLE;
      state_next.shift                  = '1;
      state_next.f.tx_buffer_empty_flag = 1'b1;
      state_next.f.tx_end_flag          = 1'b1;
    end

    // Receiver; disabling it leaves the error flags alone.
    if (rx_frame.valid && state_reg.c.receive_enable_bit) begin
      if (state_reg.f.rx_full_flag) begin
        state_next.f.overrun_error_flag = 1'b1;
      end else begin
        state_next.rx_buf = rx_frame.data;
        if (rx_frame.parity_err) begin
          state_next.f.parity_error_flag = 1'b1;
        end
        if (rx_frame.framing_err && !state_reg.m.smart_card) begin
          state_next.f.framing_error_flag = 1'b1;
        end
        if (!rx_frame.parity_err &&
            (!rx_frame.framing_err || state_reg.m.smart_card)) begin
          state_next.f.rx_full_flag = 1'b1;
        end
      end
    end

    // Module stop holds the port reset, except the mode and port registers.
    if (state_next.stop) begin
      state_next.c      = '0;
      state_next.tx_st  = SPC_TX_IDLE;
      state_next.shift  = '1;
      state_next.tx_buf = '0;
      state_next.rx_buf = '0;
      state_next.f      = '0;
      state_next.f.tx_buffer_empty_flag = 1'b1;
      state_next.f.tx_end_flag          = 1'b1;
    end

    // Requests follow the flags and their enables; the end request stays off in card mode.
    if (state_next.m.smart_card) begin
      err_any = state_next.f.overrun_error_flag ||
                state_next.f.parity_error_flag ||
                state_next.f.error_signal_received_flag;
    end else begin
      err_any = state_next.f.overrun_error_flag ||
                state_next.f.parity_error_flag ||
                state_next.f.framing_error_flag;
    end
    state_next.req.rx_error_request =
      state_next.c.rx_irq_enable && err_any;
    state_next.req.rx_full_request =
      state_next.c.rx_irq_enable && state_next.f.rx_full_flag;
    state_next.req.tx_empty_request = state_next.c.tx_empty_irq_enable &&
      state_next.f.tx_buffer_empty_flag;
    state_next.req.tx_end_request = state_next.c.tx_end_irq_enable &&
      state_next.f.tx_end_flag && !state_next.m.smart_card;

    // Fixed priority choice of the request presented first.
    if (state_next.req.rx_error_request) begin
      state_next.vec = `SPC_VEC_RXERR;
    end else if (state_next.req.rx_full_request) begin
      state_next.vec = `SPC_VEC_RXFULL;
    end else if (state_next.req.tx_empty_request) begin
      state_next.vec = `SPC_VEC_TXEMPTY;
    end else if (state_next.req.tx_end_request) begin
      state_next.vec = `SPC_VEC_TXEND;
    end else begin
      state_next.vec = `SPC_VEC_NONE;
    end

    // Pin belongs to the port registers while transmit is off.
    if (state_next.c.transmit_enable_bit) begin
      state_next.txd_o  = state_next.shift[0];
      state_next.txd_oe = 1'b1;
    end else begin
      state_next.txd_o  = state_next.port_data;
      state_next.txd_oe = state_next.port_dir;
    end

    // Read channel answers the cycle after the address is taken.
    if (state_reg.arready && arvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = '0;
      state_next.rresp  = `SPC_RESP_OKAY;
      if (araddr == `SPC_OFS_STOP) begin
        state_next.rdata[0] = state_reg.stop;
      end else if (state_reg.stop) begin
        state_next.rresp = `SPC_RESP_SLVERR;
      end else begin
        case (araddr)
          `SPC_OFS_CTRL: state_next.rdata[4:0] = state_reg.c;
          `SPC_OFS_MODE: state_next.rdata[1:0] = state_reg.m;
          `SPC_OFS_STAT: state_next.rdata[6:0] = state_reg.f;
          `SPC_OFS_TXB:  state_next.rdata[7:0] = state_reg.tx_buf;
          `SPC_OFS_RXB:  state_next.rdata[7:0] = state_reg.rx_buf;
          `SPC_OFS_PORT:
            state_next.rdata[1:0] = {state_reg.port_dir,
                                     state_reg.port_data};
          `SPC_OFS_REQ:
            state_next.rdata[6:0] = {state_reg.vec, state_reg.req};
          default: state_next.rresp = `SPC_RESP_SLVERR;
        endcase
      end
    end

    state_next.awready = !state_next.aw_full && !state_next.bvalid;
    state_next.wready  = !state_next.w_full && !state_next.bvalid;
    state_next.arready = !state_next.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; reset leaves the port in module stop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg        <= '0;
      state_reg.stop   <= `SPC_STOP_RST;
      state_reg.tx_st  <= SPC_TX_IDLE;
      state_reg.shift  <= '1;
      state_reg.txd_o  <= 1'b0;
      state_reg.f.tx_buffer_empty_flag <= 1'b1;
      state_reg.f.tx_end_flag          <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the flag and request behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_txe_request: assert property (
    state_reg.req.tx_empty_request ==
    (state_reg.c.tx_empty_irq_enable && state_reg.f.tx_buffer_empty_flag))
    else $error("tx empty request does not track its flag");
  chk_tx_end_flag_request: assert property (
    state_reg.req.tx_end_request |->
    state_reg.c.tx_end_irq_enable && state_reg.f.tx_end_flag &&
    !state_reg.m.smart_card)
    else $error("tx end request without enable, flag or in card mode");
  chk_dma_tx_clear: assert property (
    dma_tx_wr && !state_reg.stop && !do_wr &&
    state_reg.c.transmit_enable_bit && state_reg.tx_st == SPC_TX_IDLE
    |=> !state_reg.f.tx_buffer_empty_flag ##1
        state_reg.tx_st == SPC_TX_SHIFT || sync_err)
    else $error("dma write did not clear empty flag or start a frame");
  chk_dma_rx_clear: assert property (
    dma_rx_ack && !rx_frame.valid && !state_reg.stop
    |=> !state_reg.f.rx_full_flag)
    else $error("dma read did not clear the full flag");
  chk_priority_order: assert property (
    state_reg.req.tx_empty_request && !state_reg.req.rx_error_request &&
    !state_reg.req.rx_full_request |-> state_reg.vec == `SPC_VEC_TXEMPTY)
    else $error("transmit empty not chosen ahead of transmit end");
  chk_card_rx_error: assert property (
    state_reg.m.smart_card && state_reg.c.receive_enable_bit &&
    rx_frame.valid && rx_frame.parity_err && !state_reg.f.rx_full_flag &&
    !do_wr |=> state_reg.f.parity_error_flag && !state_reg.f.rx_full_flag)
    else $error("card receive error handled wrongly");
  chk_pin_port_ctrl: assert property (
    !state_reg.c.transmit_enable_bit |->
    txd_oe == state_reg.port_dir && txd_o == state_reg.port_data &&
    state_reg.tx_st == SPC_TX_IDLE)
    else $error("pin not under port control while transmit is off");
  chk_sync_hold: assert property (
    sync_err && state_reg.tx_st == SPC_TX_IDLE && !do_wr
    |=> state_reg.tx_st == SPC_TX_IDLE)
    else $error("synchronous transmission started with receive error");
  chk_stop_reset: assert property (
    state_reg.stop |-> state_reg.c == '0 && !state_reg.f.rx_full_flag &&
    state_reg.f.tx_buffer_empty_flag)
    else $error("stopped port not held in reset");

  cov_card_resend: cover property (
    state_reg.f.error_signal_received_flag && state_reg.tx_st == SPC_TX_SHIFT);
  cov_overrun: cover property ($rose(state_reg.f.overrun_error_flag));
  cov_tx_end: cover property ($rose(state_reg.req.tx_end_request));

endmodule

// File: verif/spc_remote.sv
// Remote serial party model: received frames and the card error level.
module spc_remote
  import spc_pkg::*;
(
  input  wire logic     aclk,
  input  wire logic     nack,
  output spc_rx_frame_s rx_frame,
  output logic          card_error_signal
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_frame = '0;
  // The card answers every frame with an error while nack is set.
  assign card_error_signal = nack;
  // One frame; a break is all zeros with a framing error.
  task automatic send(input logic [7:0] d, input logic pe, fe);
    @(posedge aclk);
    rx_frame <= '{1'b1, d, pe, fe};
    @(posedge aclk);
    rx_frame.valid <= 1'b0;
  endtask
endmodule

// File: verif/serial_port_interrupt_and_flag_control_tb.sv
// Self-checking bench for the serial port flag and request logic.
`include "spc_defs.svh"
module serial_port_interrupt_and_flag_control_tb
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, nack = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0, dma_tx_data = '0, dma_rx_data;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1, dma_tx_wr = 1'b0, dma_rx_ack = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, card_error_signal;
  logic txd_o, txd_oe, dma_tx_req, dma_rx_req;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] irq_vector;
  spc_rx_frame_s rx_frame;
  spc_req_s irq;
  int err_total = 0, total_checks = 0;
  spc_port dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .rx_frame,
    .card_error_signal, .dma_tx_wr, .dma_tx_data, .dma_rx_ack, .dma_rx_data,
    .irq, .irq_vector, .dma_tx_req, .dma_rx_req, .txd_o, .txd_oe);
  spc_remote u_rem (.aclk, .nack, .rx_frame, .card_error_signal);
  // Free-running 50 MHz clock.
  always #10 aclk = ~aclk;
  //////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e, input string nm);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tmo(input int n);
    if (n == 50) begin
      chk(1'b0, 1'b1, "bus timeout");
      test_done();
    end
  endtask
  // Write cycle: address and data offered together, each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    tmo(n);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    resp = rresp;
    tmo(n);
  endtask
  task automatic dma_wr(input logic [7:0] d);
    @(posedge aclk);
    dma_tx_data <= d;
    dma_tx_wr <= 1'b1;
    @(posedge aclk);
    dma_tx_wr <= 1'b0;
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence: stop state, normal transmit and receive, card mode, pin.
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`SPC_OFS_STOP);
    chk(rd, 32'h1, "stop");
    rd_reg(`SPC_OFS_CTRL);
    chk(resp, `SPC_RESP_SLVERR, "stopped");
    wr(`SPC_OFS_STOP, 32'h0);
    chk(resp, `SPC_RESP_OKAY, "stop write");
    wr(`SPC_OFS_CTRL, 32'h1f);
    chk(irq, 4'b0011, "idle irq");
    chk(irq_vector, `SPC_VEC_TXEMPTY, "idle vec");
    dma_wr(8'ha5);
    chk(dma_tx_req, 1'b0, "tx req drop");
    @(posedge aclk);
    #1;
    chk(irq, 4'b0010, "tx load");
    chk(txd_o, 1'b0, "start bit");
    repeat (16) @(posedge aclk);
    #1;
    chk(txd_o, 1'b1, "bit0");
    repeat (150) @(posedge aclk);
    chk(irq, 4'b0011, "tx end");
    u_rem.send(8'hc3, 1'b0, 1'b0);
    #1;
    chk(irq, 4'b0111, "rx full");
    chk(irq_vector, `SPC_VEC_RXFULL, "rx vec");
    chk(dma_rx_data, 8'hc3, "rx data");
    @(posedge aclk);
    dma_rx_ack <= 1'b1;
    @(posedge aclk);
    dma_rx_ack <= 1'b0;
    @(posedge aclk);
    #1;
    chk(dma_rx_req, 1'b0, "rx ack");
    u_rem.send(8'h00, 1'b1, 1'b1);
    #1;
    chk(irq_vector, `SPC_VEC_RXERR, "err vec");
    chk(dma_rx_req, 1'b0, "err no dma");
    wr(`SPC_OFS_STAT, 32'h4f);
    u_rem.send(8'h00, 1'b0, 1'b1);
    wr(`SPC_OFS_CTRL, 32'h17);
    rd_reg(`SPC_OFS_STAT);
    chk(rd, 32'h13, "break");
    // Clocked synchronous mode: a pending framing error holds the send.
    wr(`SPC_OFS_MODE, 32'h2);
    dma_wr(8'h81);
    repeat (5) @(posedge aclk);
    chk(irq, 4'b1000, "sync hold");
    chk(txd_o, 1'b1, "sync idle");
    wr(`SPC_OFS_STAT, 32'h6f);
    repeat (170) @(posedge aclk);
    chk(irq, 4'b0011, "sync sent");
    wr(`SPC_OFS_MODE, 32'h1);
    chk(irq, 4'b0010, "card irq");
    // Card receive with a parity error: error flag, no full flag.
    wr(`SPC_OFS_CTRL, 32'h1f);
    u_rem.send(8'h5a, 1'b1, 1'b0);
    #1;
    chk(irq, 4'b1010, "card rx err");
    wr(`SPC_OFS_STAT, 32'h5f);
    nack <= 1'b1;
    dma_wr(8'h3c);
    repeat (170) @(posedge aclk);
    nack <= 1'b0;
    rd_reg(`SPC_OFS_STAT);
    chk(rd, 32'h40, "card err");
    chk(irq, 4'b1000, "card err irq");
    repeat (170) @(posedge aclk);
    rd_reg(`SPC_OFS_STAT);
    chk(rd, 32'h43, "card done");
    dma_wr(8'h55);
    chk(irq, 4'b1000, "card dma");
    wr(`SPC_OFS_PORT, 32'h2);
    wr(`SPC_OFS_CTRL, 32'h13);
    #1;
    chk({txd_oe, txd_o}, 2'b10, "break pin");
    chk(irq, 4'b1010, "tx reset");
    wr(`SPC_OFS_PORT, 32'h3);
    #1;
    chk(txd_o, 1'b1, "mark pin");
    rd_reg(8'h20);
    chk(resp, `SPC_RESP_SLVERR, "unmapped");
    test_done();
  end
endmodule
